// *** pv_alarm_consts.svh ***
// Constants for the process-variable alarm monitor: offsets, fields, resets.
// Contract
// RULE1: Bit 14 of mode word enables rate alarm
// RULE2: Rate alarm uses no hysteresis
// RULE3: Alarm sets immediately beyond its threshold
// RULE4: Hysteresis accepted as binary 1 to 200
// RULE5: Programmer keeps hysteresis below deviation threshold
// RULE6: Alarm clears only hysteresis past threshold
// RULE7: Error unless low-low<low<high<high-high
// RULE8: Error unless yellow below red deviation
// RULE9: Overflow when output limited, PV off setpoint
// RULE10: Rate limit is counts per sample, word 21; code maps it to word 0x11 (17)
// RULE11: Bit 13 of mode word enables deviation alarms
// RULE12: Deviation thresholds symmetric around moving setpoint
// RULE13: Four absolute, two deviation bits in status
// RULE14: Rate alarm when sample change exceeds limit
// RULE15: Reset clears alarms, errors, previous sample
`ifndef PV_ALARM_CONSTS_SVH
`define PV_ALARM_CONSTS_SVH

// ----------------------------------------------------------------
// Register word indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_MODE1 8'h00
`define IDX_SETPOINT 8'h02
`define IDX_PV 8'h03
`define IDX_STATUS 8'h06
`define IDX_YELLOW 8'h0F
`define IDX_RED 8'h10
`define IDX_RATE 8'h11
`define IDX_HIHI 8'h18
`define IDX_HI 8'h19
`define IDX_LO 8'h1A
`define IDX_LOLO 8'h1B
`define IDX_HYST 8'h1C
`define IDX_OUTPUT 8'h1D
`define IDX_OUT_MAX 8'h1E
`define IDX_OUT_MIN 8'h1F
`define IDX_IRQ_STAT 8'h20
`define IDX_IRQ_MASK 8'h21

// ----------------------------------------------------------------
// Mode word fields
// ----------------------------------------------------------------
`define MODE_LIMIT_EN 12
`define MODE_DEV_EN 13
`define MODE_RATE_EN 14

// ----------------------------------------------------------------
// Widths, limits and reset values
// ----------------------------------------------------------------
`define DATA_W 16
`define NUM_ALARM 9
`define NUM_LEVEL 6
`define LEVEL_ABOVE 6'h33
`define HYST_MIN 16'h0001
`define HYST_MAX 16'h00C8
`define RST_WORD 16'h0000
`define RST_HYST 16'h0001
`define RST_OUT_MAX 16'hFFFF

`endif

// *** pv_alarm_pkg.sv ***
// Types shared by the process-variable alarm monitor modules.
package pv_alarm_pkg;
    // Alarm and error flags, in status word bit order (bit 0 = high_high)
    typedef struct packed {
        logic overflow;
        logic prog_err;
        logic rate;
        logic dev_red;
        logic dev_yellow;
        logic low_low;
        logic low;
        logic high;
        logic high_high;
    } alarm_bits_t;

    // Bus slave phases, Gray coded
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01,
        BUS_DONE = 2'b11
    } bus_state_t;
endpackage

// *** level_alarm.sv ***
// One threshold alarm with hysteresis toward the safe zone.
`timescale 1ns/1ps
module level_alarm (
    input wire logic clk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic sample, // Loop sample strobe
    input wire logic enable, // Alarm enabled
    input wire logic above, // 1: alarm above threshold, 0: below
    input wire logic signed [17:0] value, // Monitored value
    input wire logic signed [17:0] thresh, // Threshold
    input wire logic signed [17:0] hyst, // Hysteresis amount
    output logic alarm_r // Alarm state
);
    // ----------------------------------------------------------------
    // Alarm state
    // ----------------------------------------------------------------
    // Sets at once past threshold, clears hyst back inside it
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_r <= 1'b0; // see RULE15
        end else if (!enable) begin
            alarm_r <= 1'b0;
        end else if (sample) begin
            if (above) begin
                if (value > thresh) begin
                    alarm_r <= 1'b1; // see RULE3
                end else if (value <= thresh - hyst) begin
                    alarm_r <= 1'b0; // see RULE6
                end
            end else begin
                if (value < thresh) begin
                    alarm_r <= 1'b1; // see RULE3
                end else if (value >= thresh + hyst) begin
                    alarm_r <= 1'b0; // see RULE6
                end
            end
        end
    end
endmodule

// *** rate_alarm.sv ***
// Rate-of-change alarm: compares sample-to-sample change with a limit.
`timescale 1ns/1ps
`include "pv_alarm_consts.svh"
module rate_alarm (
    input wire logic clk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic sample, // Loop sample strobe
    input wire logic enable, // Rate alarm enabled
    input wire logic [15:0] pv, // Current process variable
    input wire logic [15:0] limit, // Counts per sample period
    output logic alarm_r // Alarm state
);
    logic [15:0] prev_r;
    logic prev_valid_r;
    logic [15:0] delta;

    // Magnitude of change since the previous sample
    always_comb begin
        delta = (pv >= prev_r) ? pv - prev_r : prev_r - pv;
    end

    // ----------------------------------------------------------------
    // Previous sample store
    // ----------------------------------------------------------------
    // First sample after reset has no reference, so it cannot alarm
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_r <= `RST_WORD;
            prev_valid_r <= 1'b0; // see RULE15
        end else if (sample) begin
            prev_r <= pv;
            prev_valid_r <= 1'b1;
        end
    end

    // No hysteresis here: re-evaluated fresh every sample (see RULE2)
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_r <= 1'b0;
        end else if (!enable) begin
            alarm_r <= 1'b0; // see RULE1
        end else if (sample) begin
            alarm_r <= prev_valid_r && (delta > limit); // see RULE14
        end
    end
endmodule

// *** pv_alarm_monitor.sv ***
// Process-variable alarm monitor with a classic Wishbone register slave.
`timescale 1ns/1ps
`include "pv_alarm_consts.svh"
module pv_alarm_monitor
    import pv_alarm_pkg::*;
(
    input wire logic clk, // 40 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    input wire logic we_i, // Wishbone write enable
    input wire logic [7:0] adr_i, // Wishbone byte address
    input wire logic [3:0] sel_i, // Wishbone byte selects
    input wire logic [31:0] dat_i, // Wishbone write data
    output logic [31:0] dat_o, // Wishbone read data
    output logic ack_o, // Wishbone acknowledge
    output logic irq // Level interrupt
);
    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Word index of a byte address
    function automatic logic [7:0] word_idx(input logic [7:0] adr);
        word_idx = {2'b00, adr[7:2]};
    endfunction

    // Merge selected byte lanes of write data into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
        merge16 = old;
        if (sel[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    bus_state_t bus_r;
    logic wr_go;
    logic [7:0] idx;
    logic [15:0] mode1_r;
    logic [15:0] setpoint_r;
    logic [15:0] pv_r;
    logic [15:0] yellow_r;
    logic [15:0] red_r;
    logic [15:0] rate_r;
    logic [15:0] hihi_r;
    logic [15:0] hi_r;
    logic [15:0] lo_r;
    logic [15:0] lolo_r;
    logic [15:0] hyst_r;
    logic [15:0] output_r;
    logic [15:0] out_max_r;
    logic [15:0] out_min_r;
    logic [15:0] hyst_nxt;
    logic [8:0] irq_stat_r;
    logic [8:0] irq_mask_r;
    logic sample_r;
    logic prog_err_r;
    logic overflow_r;
    logic rate_alarm_r;
    logic [`NUM_LEVEL-1:0] level_r;
    logic [`NUM_LEVEL-1:0] level_en;
    logic [`NUM_LEVEL-1:0] level_above;
    logic signed [17:0] lvl_val [`NUM_LEVEL];
    logic signed [17:0] lvl_thr [`NUM_LEVEL];
    logic signed [17:0] dev_mag;
    logic signed [17:0] hyst_s;
    alarm_bits_t alarms;
    logic [8:0] alarms_q;
    logic [8:0] alarm_rise;
    logic [31:0] rdata;

    // ----------------------------------------------------------------
    // Wishbone handshake
    // ----------------------------------------------------------------
    // Ack one cycle after the request, then a dead cycle; a request still
    // held into the idle cycle after it is answered again
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_r <= BUS_IDLE;
        end else begin
            case (bus_r)
                BUS_IDLE: begin
                    if (cyc_i && stb_i) begin
                        bus_r <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    bus_r <= BUS_DONE;
                end
                default: begin
                    bus_r <= BUS_IDLE;
                end
            endcase
        end
    end

    assign ack_o = (bus_r == BUS_ACK);
    assign idx = word_idx(adr_i);
    // Writes land on the edge at which the master sees ack
    assign wr_go = ack_o && cyc_i && stb_i && we_i;

    // Hysteresis held within its legal range, out-of-range writes clamp
    always_comb begin
        hyst_nxt = merge16(hyst_r, dat_i, sel_i);
        if (hyst_nxt < `HYST_MIN) begin
            hyst_nxt = `HYST_MIN; // see RULE4
        end else if (hyst_nxt > `HYST_MAX) begin
            hyst_nxt = `HYST_MAX; // see RULE4
        end
    end

    // ----------------------------------------------------------------
    // Loop parameter table writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            mode1_r <= `RST_WORD;
            setpoint_r <= `RST_WORD;
            pv_r <= `RST_WORD;
            yellow_r <= `RST_WORD;
            red_r <= `RST_WORD;
            rate_r <= `RST_WORD;
            hihi_r <= `RST_WORD;
            hi_r <= `RST_WORD;
            lo_r <= `RST_WORD;
            lolo_r <= `RST_WORD;
            hyst_r <= `RST_HYST;
            output_r <= `RST_WORD;
            out_max_r <= `RST_OUT_MAX;
            out_min_r <= `RST_WORD;
            irq_mask_r <= 9'h000;
        end else if (wr_go) begin
            if (idx == `IDX_MODE1) begin
                mode1_r <= merge16(mode1_r, dat_i, sel_i);
            end else if (idx == `IDX_SETPOINT) begin
                setpoint_r <= merge16(setpoint_r, dat_i, sel_i);
            end else if (idx == `IDX_PV) begin
                pv_r <= merge16(pv_r, dat_i, sel_i);
            end else if (idx == `IDX_YELLOW) begin
                yellow_r <= merge16(yellow_r, dat_i, sel_i);
            end else if (idx == `IDX_RED) begin
                red_r <= merge16(red_r, dat_i, sel_i);
            end else if (idx == `IDX_RATE) begin
                rate_r <= merge16(rate_r, dat_i, sel_i); // see RULE10
            end else if (idx == `IDX_HIHI) begin
                hihi_r <= merge16(hihi_r, dat_i, sel_i);
            end else if (idx == `IDX_HI) begin
                hi_r <= merge16(hi_r, dat_i, sel_i);
            end else if (idx == `IDX_LO) begin
                lo_r <= merge16(lo_r, dat_i, sel_i);
            end else if (idx == `IDX_LOLO) begin
                lolo_r <= merge16(lolo_r, dat_i, sel_i);
            end else if (idx == `IDX_HYST) begin
                hyst_r <= hyst_nxt;
            end else if (idx == `IDX_OUTPUT) begin
                output_r <= merge16(output_r, dat_i, sel_i);
            end else if (idx == `IDX_OUT_MAX) begin
                out_max_r <= merge16(out_max_r, dat_i, sel_i);
            end else if (idx == `IDX_OUT_MIN) begin
                out_min_r <= merge16(out_min_r, dat_i, sel_i);
            end else if (idx == `IDX_IRQ_MASK) begin
                irq_mask_r <= {dat_i[8] & sel_i[1], dat_i[7:0] & {8{sel_i[0]}}};
            end
        end
    end

    // A process-variable write is the loop sample; evaluated next cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            sample_r <= 1'b0;
        end else begin
            sample_r <= wr_go && (idx == `IDX_PV) && (sel_i[1:0] != 2'b00);
        end
    end

    // ----------------------------------------------------------------
    // Level alarms: four absolute, two deviation
    // ----------------------------------------------------------------
    // Deviation magnitude taken around the live setpoint (see RULE12)
    always_comb begin
        if (pv_r >= setpoint_r) begin
            dev_mag = $signed({2'b00, pv_r - setpoint_r});
        end else begin
            dev_mag = $signed({2'b00, setpoint_r - pv_r});
        end
    end

    assign hyst_s = $signed({2'b00, hyst_r});
    assign level_above = `LEVEL_ABOVE;
    assign lvl_thr[0] = $signed({2'b00, hihi_r});
    assign lvl_thr[1] = $signed({2'b00, hi_r});
    assign lvl_thr[2] = $signed({2'b00, lo_r});
    assign lvl_thr[3] = $signed({2'b00, lolo_r});
    assign lvl_thr[4] = $signed({2'b00, yellow_r});
    assign lvl_thr[5] = $signed({2'b00, red_r});

    genvar g;
    generate
        for (g = 0; g < `NUM_LEVEL; g = g + 1) begin : gen_level
            if (g < 4) begin : gen_abs
                assign lvl_val[g] = $signed({2'b00, pv_r});
                assign level_en[g] = mode1_r[`MODE_LIMIT_EN];
            end else begin : gen_dev
                assign lvl_val[g] = dev_mag;
                assign level_en[g] = mode1_r[`MODE_DEV_EN]; // see RULE11
            end
            level_alarm u_level (
                .clk(clk),
                .rst(rst),
                .sample(sample_r),
                .enable(level_en[g]),
                .above(level_above[g]),
                .value(lvl_val[g]),
                .thresh(lvl_thr[g]),
                .hyst(hyst_s),
                .alarm_r(level_r[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Rate-of-change alarm
    // ----------------------------------------------------------------
    rate_alarm u_rate (
        .clk(clk),
        .rst(rst),
        .sample(sample_r),
        .enable(mode1_r[`MODE_RATE_EN]), // see RULE1
        .pv(pv_r),
        .limit(rate_r), // see RULE10
        .alarm_r(rate_alarm_r)
    );

    // ----------------------------------------------------------------
    // Error checks
    // ----------------------------------------------------------------
    // Ordering checked every cycle, so a bad table shows at once
    always_ff @(posedge clk) begin
        if (rst) begin
            prog_err_r <= 1'b0; // see RULE15
        end else begin
            prog_err_r <= !((lolo_r < lo_r) && (lo_r < hi_r) && (hi_r < hihi_r)) // see RULE7
                          || !(yellow_r < red_r); // see RULE8
        end
    end

    // Output pinned at a limit while the loop has not reached setpoint
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_r <= 1'b0; // see RULE15
        end else if (sample_r) begin
            overflow_r <= ((output_r >= out_max_r) || (output_r <= out_min_r))
                          && (pv_r != setpoint_r); // see RULE9
        end
    end

    // ----------------------------------------------------------------
    // Status word and interrupts
    // ----------------------------------------------------------------
    // One bit per alarm in the status word (see RULE13)
    always_comb begin
        alarms.high_high = level_r[0];
        alarms.high = level_r[1];
        alarms.low = level_r[2];
        alarms.low_low = level_r[3];
        alarms.dev_yellow = level_r[4];
        alarms.dev_red = level_r[5];
        alarms.rate = rate_alarm_r;
        alarms.prog_err = prog_err_r;
        alarms.overflow = overflow_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            alarms_q <= 9'h000;
        end else begin
            alarms_q <= alarms;
        end
    end

    assign alarm_rise = alarms & ~alarms_q;

    // Write one to clear; a new rise in the same cycle wins the race
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_r <= 9'h000;
        end else if (wr_go && (idx == `IDX_IRQ_STAT)) begin
            irq_stat_r <= (irq_stat_r & ~{dat_i[8] & sel_i[1], dat_i[7:0] & {8{sel_i[0]}}})
                          | alarm_rise;
        end else begin
            irq_stat_r <= irq_stat_r | alarm_rise;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Unmapped words read as zero and still acknowledge
    always_comb begin
        rdata = 32'h0000_0000;
        if (idx == `IDX_MODE1) begin
            rdata[15:0] = mode1_r;
        end else if (idx == `IDX_SETPOINT) begin
            rdata[15:0] = setpoint_r;
        end else if (idx == `IDX_PV) begin
            rdata[15:0] = pv_r;
        end else if (idx == `IDX_STATUS) begin
            rdata[8:0] = alarms;
        end else if (idx == `IDX_YELLOW) begin
            rdata[15:0] = yellow_r;
        end else if (idx == `IDX_RED) begin
            rdata[15:0] = red_r;
        end else if (idx == `IDX_RATE) begin
            rdata[15:0] = rate_r;
        end else if (idx == `IDX_HIHI) begin
            rdata[15:0] = hihi_r;
        end else if (idx == `IDX_HI) begin
            rdata[15:0] = hi_r;
        end else if (idx == `IDX_LO) begin
            rdata[15:0] = lo_r;
        end else if (idx == `IDX_LOLO) begin
            rdata[15:0] = lolo_r;
        end else if (idx == `IDX_HYST) begin
            rdata[15:0] = hyst_r;
        end else if (idx == `IDX_OUTPUT) begin
            rdata[15:0] = output_r;
        end else if (idx == `IDX_OUT_MAX) begin
            rdata[15:0] = out_max_r;
        end else if (idx == `IDX_OUT_MIN) begin
            rdata[15:0] = out_min_r;
        end else if (idx == `IDX_IRQ_STAT) begin
            rdata[8:0] = irq_stat_r;
        end else if (idx == `IDX_IRQ_MASK) begin
            rdata[8:0] = irq_mask_r;
        end
    end

    // Read data captured as the request arrives, valid with ack
    always_ff @(posedge clk) begin
        if (rst) begin
            dat_o <= 32'h0000_0000;
        end else if (bus_r == BUS_IDLE && cyc_i && stb_i) begin
            dat_o <= rdata;
        end
    end
endmodule

// *** pv_alarm_monitor_assertions.sv ***
// Bus, interrupt and status checks for the alarm monitor.
`timescale 1ns/1ps
module pv_alarm_checker (
    input wire logic clk, // Clock
    input wire logic rst, // Sync reset
    input wire logic cyc_i, // Cycle
    input wire logic stb_i, // Strobe
    input wire logic we_i, // Write
    input wire logic [7:0] adr_i, // Address
    input wire logic [3:0] sel_i, // Selects
    input wire logic [31:0] dat_i, // Write data
    input wire logic [31:0] dat_o, // Read data
    input wire logic ack_o, // Ack
    input wire logic irq // Interrupt
);
    logic [3:0] wr_hist_r;
    logic [7:0] mode_hi_r;
    logic stat_rd;
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    // Status read acked
    assign stat_rd = ack_o && !we_i && adr_i[7:2] == 6'h06;
    // Write-ack history and mode shadow
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_hist_r <= 4'h0;
            mode_hi_r <= 8'h00;
        end else begin
            wr_hist_r <= {wr_hist_r[2:0], ack_o && we_i};
            if (ack_o && we_i && adr_i[7:2] == 6'h00 && sel_i[1]) begin
                mode_hi_r <= dat_i[15:8];
            end
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_spacing: assert property (ack_o |=> !ack_o [*2])
        else $error("ack too soon");
    a_ack_answer: assert property ($rose(cyc_i && stb_i) |=> ack_o)
        else $error("late ack");
    a_ack_in_cycle: assert property (ack_o |-> cyc_i && stb_i)
        else $error("stray ack");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !ack_o && !irq && dat_o == 32'h0)
        else $error("reset not quiet");
    a_irq_fall: assert property ($fell(irq) |-> wr_hist_r[0])
        else $error("irq fell unprompted");
    a_irq_rise: assert property ($rose(irq) |-> |wr_hist_r)
        else $error("irq rose unprompted");
    a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_status_spare: assert property (stat_rd |-> dat_o[15:9] == 7'h00)
        else $error("spare status set");
    a_rate_gate: assert property (stat_rd && !mode_hi_r[6] |-> !dat_o[6])
        else $error("rate alarm while off");
    a_dev_gate: assert property (stat_rd && !mode_hi_r[5] |-> dat_o[5:4] == 2'b00)
        else $error("deviation alarm while off");
    // Main scenarios reached
    c_irq: cover property ($rose(irq));
    c_rate: cover property (stat_rd && dat_o[6]);
    c_ovf: cover property (stat_rd && dat_o[8]);
    c_lolo: cover property (stat_rd && dat_o[3]);
endmodule

bind pv_alarm_monitor pv_alarm_checker pv_alarm_checker_inst (.clk(clk), .rst(rst),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq(irq));

// *** pv_alarm_monitor_test.sv ***
// Self-checking bench for the alarm monitor.
`timescale 1ns/1ps
`include "pv_alarm_consts.svh"
module pv_alarm_monitor_test;
    logic clk, rst, cyc_i, stb_i, we_i, ack_o, irq;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic [15:0] q;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Setup: index, value; thresholds ordered
    logic [23:0] cfg [12] = '{{`IDX_LOLO, 16'h0064}, {`IDX_LO, 16'h00C8}, {`IDX_HI, 16'h0320},
        {`IDX_HIHI, 16'h0384}, {`IDX_YELLOW, 16'h0032}, {`IDX_RED, 16'h0096},
        {`IDX_RATE, 16'h0064}, {`IDX_HYST, 16'h000A}, {`IDX_OUT_MIN, 16'h0010},
        {`IDX_OUTPUT, 16'h0100}, {`IDX_OUT_MAX, 16'hF000}, {`IDX_MODE1, 16'h7000}};
    // Rows: setpoint, process variable, status
    logic [47:0] rows [18] = '{48'h01F401F40000, 48'h01F402300010, 48'h01F402210010,
        48'h01F4021C0000, 48'h01F403210072, 48'h01F4031B0032, 48'h01F403160030,
        48'h01F403850073, 48'h01F4037F0033, 48'h01F401900050, 48'h01F400C70074,
        48'h01F400CD0034, 48'h01F40063007C, 48'h01F4006E0034, 48'h006E006E0004,
        48'h006E00D20010, 48'h006E01370070, 48'h006E019C0070};
    logic [15:0] hyst_in [3] = '{16'h0000, 16'h00C9, 16'h00C8};
    logic [15:0] hyst_exp [3] = '{`HYST_MIN, `HYST_MAX, `HYST_MAX};

    pv_alarm_monitor pv_alarm_monitor_inst (.clk(clk), .rst(rst), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .irq(irq));

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // About four hundred cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("checked %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, exp, got);
        end
    endtask
    // Classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx[5:0], 2'b00};
        dat_i <= {16'h0000, d};
        @(posedge clk);
        while (ack_o !== 1'b1) @(posedge clk);
        q = dat_o[15:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic rc(input string n, input logic [7:0] idx, input logic [15:0] m, e);
        wb(1'b0, idx, 16'h0000);
        check(n, q & m, e);
    endtask
    // Sample: process-variable write; alarms settle one edge after the write lands
    task automatic samp(input logic [15:0] sp, pv);
        wb(1'b1, `IDX_SETPOINT, sp);
        wb(1'b1, `IDX_PV, pv);
        repeat (3) @(posedge clk);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        check("irq", 16'(irq), 16'(e));
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        sel_i = 4'h3;
        adr_i = 8'h00;
        dat_i = 32'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // Zero thresholds after reset: only ordering error shows
        rc("status", `IDX_STATUS, 16'hFFFF, 16'h0080);
        rc("hyst", `IDX_HYST, 16'hFFFF, `RST_HYST);
        rc("out max", `IDX_OUT_MAX, 16'hFFFF, `RST_OUT_MAX);
        rc("unmapped", 8'h3F, 16'hFFFF, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            wb(1'b1, cfg[i][23:16], cfg[i][15:0]);
        end
        for (int i = 0; i < 18; i++) begin
            samp(rows[i][47:32], rows[i][31:16]);
            rc("status", `IDX_STATUS, 16'hFFFF, rows[i][15:0]);
        end
        // Disabling hides deviation and rate
        wb(1'b1, `IDX_MODE1, 16'h1000);
        rc("disabled", `IDX_STATUS, 16'hFFFF, 16'h0000);
        // Equal thresholds break strict ordering
        wb(1'b1, `IDX_LO, 16'h0064);
        rc("order abs", `IDX_STATUS, 16'h0080, 16'h0080);
        wb(1'b1, `IDX_LO, 16'h00C8);
        rc("order ok", `IDX_STATUS, 16'h0080, 16'h0000);
        wb(1'b1, `IDX_YELLOW, 16'h0096);
        rc("order dev", `IDX_STATUS, 16'h0080, 16'h0080);
        wb(1'b1, `IDX_YELLOW, 16'h0032);
        // Output at upper limit, then on setpoint
        wb(1'b1, `IDX_OUTPUT, 16'hF000);
        samp(16'h006E, 16'h0137);
        rc("ovf high", `IDX_STATUS, 16'h0100, 16'h0100);
        samp(16'h006E, 16'h006E);
        rc("ovf on sp", `IDX_STATUS, 16'h0100, 16'h0000);
        // Interrupt: clear, unmask, raise at lower limit, mask, unmask, clear
        wb(1'b1, `IDX_IRQ_STAT, 16'h01FF);
        rc("irq stat", `IDX_IRQ_STAT, 16'hFFFF, 16'h0000);
        wb(1'b1, `IDX_IRQ_MASK, 16'h0100);
        wb(1'b1, `IDX_OUTPUT, 16'h0010);
        irq_is(1'b0);
        samp(16'h006E, 16'h0137);
        rc("ovf low", `IDX_STATUS, 16'h0100, 16'h0100);
        irq_is(1'b1);
        wb(1'b1, `IDX_IRQ_MASK, 16'h0000);
        irq_is(1'b0);
        wb(1'b1, `IDX_IRQ_MASK, 16'h0100);
        irq_is(1'b1);
        wb(1'b1, `IDX_IRQ_STAT, 16'h0100);
        irq_is(1'b0);
        // Out-of-range hysteresis clamps
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, `IDX_HYST, hyst_in[i]);
            rc("hyst clamp", `IDX_HYST, 16'hFFFF, hyst_exp[i]);
        end
        // Mid-run reset must forget the old sample
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rc("status rst", `IDX_STATUS, 16'hFFFF, 16'h0080);
        irq_is(1'b0);
        wb(1'b1, `IDX_MODE1, 16'h4000);
        samp(16'h0000, 16'h0FFF);
        rc("first", `IDX_STATUS, 16'h0040, 16'h0000);
        samp(16'h0000, 16'h0FFE);
        rc("rate zero", `IDX_STATUS, 16'h0040, 16'h0040);
        finish_test();
    end
endmodule
